// ### design/fcct_pkg.sv
// shared constants and types of the four channel counter timer
package fcct_pkg;

  // ****************************************
  // control word fields
  // ****************************************
  localparam int CW_IRQ_EN_BIT     = 7;
  localparam int CW_TIMER_BIT      = 6;
  localparam int CW_PRESC_BIT      = 5;
  localparam int CW_RISING_BIT     = 4;
  localparam int CW_EXT_START_BIT  = 3;
  localparam int CW_TC_FOLLOWS_BIT = 2;
  localparam int CW_SW_RESET_BIT   = 1;
  localparam int CW_IS_CONTROL_BIT = 0;

  // ****************************************
  // reset values, vector layout, opcodes
  // ****************************************
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam logic [7:0] RELOAD_RESET    = 8'h00;
  localparam logic [4:0] VEC_BASE_RESET  = 5'h00;
  localparam int         VEC_CH_LSB      = 1;
  localparam int         VEC_BASE_LSB    = 3;
  localparam logic [7:0] RETURN_FROM_IRQ_OPCODE_FIRST_BYTE = 8'hed;
  localparam logic [7:0] RETURN_FROM_IRQ_OPCODE_LAST_BYTE  = 8'h4d;

  // ****************************************
  // prescaler, channel count, run states
  // ****************************************
  localparam int         PRESC_DIV_LO  = 16;
  localparam int         PRESC_DIV_HI  = 256;
  localparam logic [7:0] PRESC_LAST_LO = 8'(PRESC_DIV_LO - 1);
  localparam logic [7:0] PRESC_LAST_HI = 8'(PRESC_DIV_HI - 1);
  localparam int         NUM_CHANNELS  = 4;

  typedef enum logic [1:0] {
    RUN_STOPPED,
    RUN_ARMED,
    RUN_COUNTING
  } fcct_run_t;

endpackage : fcct_pkg

// ### design/fcct_channel.sv
// one counter timer channel: control word, reload constant, prescaler, down-counter
`timescale 1ns/1ps
module fcct_channel
  import fcct_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ctrl_we_i,
  input  wire logic       tc_we_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       trig_i,
  output logic      [7:0] count_o,
  output logic            zero_o,
  output logic            tc_expected_o,
  output logic            irq_en_o
);

  logic [7:0] ctrl, next_ctrl;
  logic [7:0] reload, next_reload;
  logic [7:0] count, next_count;
  logic [7:0] psc, next_psc;
  logic       zero, next_zero;
  logic       tc_exp, next_tc_exp;
  fcct_run_t  state, next_state;
  logic       trig_s1, trig_s2, trig_s3;
  logic       act_edge, tick, timer, dec;

  // ****************************************
  // trigger sync and edge select
  // ****************************************
  always_ff @(posedge clk_i) begin
    trig_s1 <= trig_i;
    trig_s2 <= trig_s1;
    trig_s3 <= trig_s2;
  end

  // a slope change by a control word counts as an active edge
  assign act_edge = (ctrl[CW_RISING_BIT] ? (trig_s2 & ~trig_s3) : (~trig_s2 & trig_s3))
                  | (ctrl_we_i & (wdata_i[CW_RISING_BIT] != ctrl[CW_RISING_BIT]));
  assign timer = ctrl[CW_TIMER_BIT];
  assign tick  = ctrl[CW_PRESC_BIT] ? (psc == PRESC_LAST_HI)
                                    : (psc[3:0] == PRESC_LAST_LO[3:0]);
  assign dec   = (state == RUN_COUNTING) & (timer ? tick : act_edge);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_ctrl   = ctrl;
    next_reload = reload;
    next_count  = count;
    next_psc    = psc;
    next_zero   = 1'b0;
    next_tc_exp = tc_exp;
    next_state  = state;
    if (state == RUN_COUNTING && timer) begin
      next_psc = psc + 8'h01;
    end
    if (dec) begin
      if (count == 8'h01) begin
        next_count = reload; // zero stored means 256
        next_zero  = 1'b1;
      end else begin
        next_count = count - 8'h01;
      end
    end
    if (state == RUN_ARMED && act_edge) begin
      next_state = RUN_COUNTING;
      next_psc   = 8'h00;
    end
    if (ctrl_we_i) begin
      next_ctrl   = wdata_i;
      next_tc_exp = wdata_i[CW_TC_FOLLOWS_BIT];
      if (wdata_i[CW_SW_RESET_BIT]) begin
        next_state = RUN_STOPPED;
      end
    end
    if (tc_we_i) begin
      next_reload = wdata_i;
      next_tc_exp = 1'b0;
      // a running channel finishes its count before taking the new constant
      if (state != RUN_COUNTING) begin
        next_count = wdata_i;
        next_psc   = 8'h00;
        next_state = (timer && ctrl[CW_EXT_START_BIT]) ? RUN_ARMED : RUN_COUNTING;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl   <= CTRL_RESET;
      reload <= RELOAD_RESET;
      count  <= RELOAD_RESET;
      psc    <= 8'h00;
      zero   <= 1'b0;
      tc_exp <= 1'b0;
      state  <= RUN_STOPPED;
    end else begin
      ctrl   <= next_ctrl;
      reload <= next_reload;
      count  <= next_count;
      psc    <= next_psc;
      zero   <= next_zero;
      tc_exp <= next_tc_exp;
      state  <= next_state;
    end
  end

  assign count_o       = count;
  assign zero_o        = zero;
  assign tc_expected_o = tc_exp;
  assign irq_en_o      = ctrl[CW_IRQ_EN_BIT];

  // ****************************************
  // checks
  // ****************************************
  a_reload_at_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    zero |-> count == $past(reload)) else $error("no reload at zero count");
  a_initial_load: assert property (@(posedge clk_i) disable iff (rst_i)
    tc_we_i && state != RUN_COUNTING |=> count == $past(wdata_i))
    else $error("constant not copied into counter");
  a_soft_reset_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    state == RUN_STOPPED && !tc_we_i |=> $stable(count) && !zero)
    else $error("stopped channel still counts");
  a_timer_step: assert property (@(posedge clk_i) disable iff (rst_i)
    state == RUN_COUNTING && timer && !tick && !tc_we_i |=> $stable(count))
    else $error("timer moved without prescaler tick");
  c_zero_seen: cover property (@(posedge clk_i) disable iff (rst_i) zero && timer);
  c_counter_zero: cover property (@(posedge clk_i) disable iff (rst_i) zero && !timer);
  c_armed_start: cover property (@(posedge clk_i) disable iff (rst_i)
    state == RUN_ARMED ##1 state == RUN_COUNTING);

endmodule : fcct_channel

// ### design/fcct_counter_timer.sv
// four channel counter timer with daisy-chain vectored interrupts
`timescale 1ns/1ps
module fcct_counter_timer
  import fcct_pkg::*;
(
  input  wire logic       CLOCK_I,
  input  wire logic       RST_I,
  input  wire logic       CHIP_ENABLE_N_I,
  input  wire logic       CHANNEL_SELECT_LO_I,
  input  wire logic       CHANNEL_SELECT_HI_I,
  input  wire logic       READ_STROBE_N_I,
  input  wire logic       IO_CYCLE_STROBE_N_I,
  input  wire logic       OPCODE_FETCH_STROBE_N_I,
  input  wire logic [7:0] DATA_I,
  output logic      [7:0] DATA_O,
  output logic            DATA_OE_O,
  input  wire logic [3:0] COUNT_TRIGGER_INPUT_I,
  output logic      [2:0] ZERO_COUNT_PULSE_OUT_O,
  output logic            INT_N_O,
  input  wire logic       PRIORITY_CHAIN_IN_I,
  output logic            PRIORITY_CHAIN_OUT_O
);

  localparam int NCH = NUM_CHANNELS;

  logic [1:0]     sel;
  logic           io_wr, io_rd, ack, fetch;
  logic           io_wr_d, io_rd_d, ack_d, fetch_d;
  logic           wr_start, ack_start, fetch_end;
  logic [NCH-1:0] ctrl_we, tc_we, zero, tc_exp, irq_en, req;
  logic [7:0]     count [NCH];
  logic           vec_we;

  // ****************************************
  // bus decode
  // ****************************************
  assign sel   = {CHANNEL_SELECT_HI_I, CHANNEL_SELECT_LO_I};
  assign io_wr = ~CHIP_ENABLE_N_I & ~IO_CYCLE_STROBE_N_I & OPCODE_FETCH_STROBE_N_I
               & READ_STROBE_N_I;
  assign io_rd = ~CHIP_ENABLE_N_I & ~IO_CYCLE_STROBE_N_I & OPCODE_FETCH_STROBE_N_I
               & ~READ_STROBE_N_I;
  assign ack   = ~OPCODE_FETCH_STROBE_N_I & ~IO_CYCLE_STROBE_N_I;
  assign fetch = ~OPCODE_FETCH_STROBE_N_I & IO_CYCLE_STROBE_N_I & ~READ_STROBE_N_I;

  // one write per strobe, however long the strobe stays low
  assign wr_start  = io_wr & ~io_wr_d;
  assign ack_start = ack & ~ack_d;
  assign fetch_end = fetch_d & ~fetch;

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      io_wr_d <= 1'b0;
      io_rd_d <= 1'b0;
      ack_d   <= 1'b0;
      fetch_d <= 1'b0;
    end else begin
      io_wr_d <= io_wr;
      io_rd_d <= io_rd;
      ack_d   <= ack;
      fetch_d <= fetch;
    end
  end

  // ****************************************
  // channels
  // ****************************************
  assign vec_we = wr_start & (sel == 2'd0) & ~tc_exp[0] & ~DATA_I[CW_IS_CONTROL_BIT];

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    assign tc_we[i]   = wr_start & (sel == 2'(i)) & tc_exp[i];
    assign ctrl_we[i] = wr_start & (sel == 2'(i)) & ~tc_exp[i]
                      & DATA_I[CW_IS_CONTROL_BIT];
    fcct_channel i_fcct_channel (
      .clk_i         (CLOCK_I),
      .rst_i         (RST_I),
      .ctrl_we_i     (ctrl_we[i]),
      .tc_we_i       (tc_we[i]),
      .wdata_i       (DATA_I),
      .trig_i        (COUNT_TRIGGER_INPUT_I[i]),
      .count_o       (count[i]),
      .zero_o        (zero[i]),
      .tc_expected_o (tc_exp[i]),
      .irq_en_o      (irq_en[i])
    );
  end

  assign ZERO_COUNT_PULSE_OUT_O = zero[2:0];

  // ****************************************
  // interrupt chain state
  // ****************************************
  logic [NCH-1:0] pend, next_pend;
  logic [NCH-1:0] svc, next_svc;
  logic [4:0]     vec_base, next_vec_base;
  logic [7:0]     op, next_op;
  logic           return_from_irq_opcode_arm, next_return_from_irq_opcode_arm;
  logic [7:0]     dout, next_dout;
  logic [1:0]     win;
  logic           win_ok;

  // a channel may request only if nothing at or above it is in service
  always_comb begin
    logic blocked;
    blocked = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      blocked = blocked | svc[i];
      req[i]  = pend[i] & ~blocked;
    end
  end

  always_comb begin
    win    = 2'd0;
    win_ok = 1'b0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (req[i]) begin
        win    = 2'(i); // lowest index wins
        win_ok = 1'b1;
      end
    end
  end

  always_comb begin
    logic done;
    done          = 1'b0;
    next_svc      = svc;
    next_vec_base = vec_base;
    next_op       = op;
    next_return_from_irq_opcode_arm = return_from_irq_opcode_arm;
    // disabling a channel drops its pending request
    next_pend     = pend & irq_en;
    if (ack_start && PRIORITY_CHAIN_IN_I && win_ok) begin
      next_pend[win] = 1'b0;
      next_svc[win]  = 1'b1;
    end
    // set wins over the acknowledge clear
    next_pend = next_pend | (zero & irq_en);
    if (vec_we) begin
      next_vec_base = DATA_I[7:VEC_BASE_LSB];
    end
    if (fetch) begin
      next_op = DATA_I;
    end
    if (fetch_end) begin
      next_return_from_irq_opcode_arm = (op == RETURN_FROM_IRQ_OPCODE_FIRST_BYTE);
      if (return_from_irq_opcode_arm && op == RETURN_FROM_IRQ_OPCODE_LAST_BYTE && PRIORITY_CHAIN_IN_I) begin
        for (int i = 0; i < NCH; i++) begin
          if (svc[i] && !done) begin
            next_svc[i] = 1'b0;
            done        = 1'b1;
          end
        end
      end
    end
  end

  // ****************************************
  // read data and vector
  // ****************************************
  always_comb begin
    next_dout = count[sel];
    if (ack_start && win_ok) begin
      next_dout = {vec_base, win, 1'b0};
    end else if (ack) begin
      next_dout = dout;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      pend     <= '0;
      svc      <= '0;
      vec_base <= VEC_BASE_RESET;
      op       <= 8'h00;
      return_from_irq_opcode_arm <= 1'b0;
      dout     <= 8'h00;
    end else begin
      pend     <= next_pend;
      svc      <= next_svc;
      vec_base <= next_vec_base;
      op       <= next_op;
      return_from_irq_opcode_arm <= next_return_from_irq_opcode_arm;
      dout     <= next_dout;
    end
  end

  logic ack_drive;
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      ack_drive <= 1'b0;
    end else begin
      ack_drive <= ack & (ack_start ? (win_ok & PRIORITY_CHAIN_IN_I) : ack_drive);
    end
  end

  assign DATA_O    = dout;
  assign DATA_OE_O = (io_rd & io_rd_d) | (ack & ack_drive);
  assign INT_N_O   = ~(PRIORITY_CHAIN_IN_I & |req);
  // after the first return byte the chain opens for one fetch unless a channel is in service, so lower devices see the rest
  assign PRIORITY_CHAIN_OUT_O = PRIORITY_CHAIN_IN_I & ~|svc
                              & (~|pend | return_from_irq_opcode_arm);

  // ****************************************
  // checks
  // ****************************************
  a_chain_in_low: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    !PRIORITY_CHAIN_IN_I |-> !PRIORITY_CHAIN_OUT_O && INT_N_O)
    else $error("device active without priority");
  a_pending_blocks: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (|pend && !return_from_irq_opcode_arm) || |svc |-> !PRIORITY_CHAIN_OUT_O)
    else $error("chain out high while interrupt outstanding");
  a_enabled_zero_irq: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    zero[0] && irq_en[0] && PRIORITY_CHAIN_IN_I && !ack_start |=> !INT_N_O)
    else $error("channel 0 zero count gave no request");
  a_vector_layout: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    ack_start && win_ok && PRIORITY_CHAIN_IN_I |=> DATA_O == {vec_base, $past(win), 1'b0}
    && svc[$past(win)]) else $error("wrong vector or service state");
  a_read_count: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    io_rd |=> dout == $past(count[sel])) else $error("read data is not live count");
  c_ack_served: cover property (@(posedge CLOCK_I) disable iff (RST_I)
    ack_start && win_ok ##[1:8] DATA_OE_O);
  c_return_from_irq_opcode_open: cover property (@(posedge CLOCK_I) disable iff (RST_I)
    return_from_irq_opcode_arm && PRIORITY_CHAIN_OUT_O);

endmodule : fcct_counter_timer

// ### verif/fcct_cpu_model.sv
// processor side model: io write, io read, interrupt acknowledge and opcode fetch
`timescale 1ns/1ps
module fcct_cpu_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] dev_data_i,
  input  wire logic       dev_oe_i,
  output logic            ce_n_o,
  output logic            sel_lo_o,
  output logic            sel_hi_o,
  output logic            rd_n_o,
  output logic            io_cycle_strobe_n_n_o,
  output logic            m1_n_o,
  output logic      [7:0] data_o
);
  // ****************************************
  // idle bus and release
  // ****************************************
  initial begin
    {ce_n_o, rd_n_o, io_cycle_strobe_n_n_o, m1_n_o} = 4'hf;
    {sel_hi_o, sel_lo_o} = 2'h0;
    data_o = 8'h5a;
  end

  // released data shows the inverse, so a stale byte is never mistaken for a new one
  task automatic release_bus();
    {ce_n_o, rd_n_o, io_cycle_strobe_n_n_o, m1_n_o} = 4'hf;
    data_o = ~data_o;
    @(posedge clk_i);
    #1;
  endtask : release_bus

  // ****************************************
  // bus cycles, each entered just after an edge
  // ****************************************
  task automatic io_wr(input logic [1:0] ch, input logic [7:0] d);
    {sel_hi_o, sel_lo_o} = ch;
    data_o = d;
    {ce_n_o, io_cycle_strobe_n_n_o} = 2'h0;
    @(posedge clk_i);
    #1;
    release_bus();
  endtask : io_wr

  // bounded wait for the device to drive the bus
  task automatic take(output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    for (int k = 0; k < 4 && !ok; k++) begin
      @(posedge clk_i);
      #1;
      if (dev_oe_i === 1'b1) begin
        ok = 1'b1;
        d = dev_data_i;
      end
    end
    release_bus();
  endtask : take

  task automatic io_rd(input logic [1:0] ch, output logic [7:0] d, output logic ok);
    {sel_hi_o, sel_lo_o} = ch;
    {ce_n_o, io_cycle_strobe_n_n_o, rd_n_o} = 3'h0;
    take(d, ok);
  endtask : io_rd

  task automatic int_ack(output logic [7:0] d, output logic ok);
    {io_cycle_strobe_n_n_o, m1_n_o} = 2'h0;
    take(d, ok);
  endtask : int_ack

  task automatic fetch(input logic [7:0] op);
    data_o = op;
    {m1_n_o, rd_n_o} = 2'h0;
    repeat (2) @(posedge clk_i);
    #1;
    release_bus();
  endtask : fetch
endmodule : fcct_cpu_model

// ### verif/fcct_counter_timer_tb.sv
// self-checking bench of the four channel counter timer
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("BAD %0t got %h exp %h", $time, (got), (exp)); \
    end \
  end
module fcct_counter_timer_tb
  import fcct_pkg::*;
;
  logic       clk;
  logic       rst;
  logic [3:0] trig;
  logic       chain_in;
  logic       ce_n;
  logic       sel_lo;
  logic       sel_hi;
  logic       rd_n;
  logic       io_cycle_strobe_n_n;
  logic       m1_n;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       oe;
  logic       int_n;
  logic       chain_out;
  logic [2:0] zc;
  int         failures;
  int         comparisons;

  fcct_counter_timer i_fcct_counter_timer (
    .CLOCK_I(clk), .RST_I(rst), .CHIP_ENABLE_N_I(ce_n),
    .CHANNEL_SELECT_LO_I(sel_lo), .CHANNEL_SELECT_HI_I(sel_hi),
    .READ_STROBE_N_I(rd_n), .IO_CYCLE_STROBE_N_I(io_cycle_strobe_n_n),
    .OPCODE_FETCH_STROBE_N_I(m1_n), .DATA_I(wdata), .DATA_O(rdata),
    .DATA_OE_O(oe), .COUNT_TRIGGER_INPUT_I(trig), .ZERO_COUNT_PULSE_OUT_O(zc),
    .INT_N_O(int_n), .PRIORITY_CHAIN_IN_I(chain_in), .PRIORITY_CHAIN_OUT_O(chain_out)
  );

  fcct_cpu_model i_fcct_cpu_model (
    .clk_i(clk), .dev_data_i(rdata), .dev_oe_i(oe), .ce_n_o(ce_n),
    .sel_lo_o(sel_lo), .sel_hi_o(sel_hi), .rd_n_o(rd_n), .io_cycle_strobe_n_n_o(io_cycle_strobe_n_n),
    .m1_n_o(m1_n), .data_o(wdata)
  );

  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  // ****************************************
  // helpers
  // ****************************************
  task automatic finish_test();
    if (failures == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  task automatic watch(input int cyc, output logic [2:0] hit);
    hit = 3'h0;
    repeat (cyc) begin
      @(posedge clk);
      #1;
      hit = hit | zc;
    end
  endtask : watch

  // cycles up to the next channel 0 pulse, always stepping past a pulse that still stands
  task automatic wait_zero0(input int lim, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      if (n > lim) begin
        failures++;
        finish_test();
      end
    end while (zc[0] !== 1'b1);
  endtask : wait_zero0

  // falling edge is the active one in every scenario here
  task automatic trig_pulse(input logic [3:0] mask, output logic [2:0] hit);
    trig = trig | mask;
    repeat (4) @(posedge clk);
    #1;
    trig = trig & ~mask;
    watch(6, hit);
  endtask : trig_pulse

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [7:0] d;
    logic       ok;
    logic [2:0] hit;
    int         n;
    failures = 0;
    comparisons = 0;
    rst = 1'b1;
    trig = 4'h0;
    chain_in = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    `CHK({int_n, chain_out, zc, oe}, 6'b110000)
    i_fcct_cpu_model.io_wr(2'h0, 8'ha8);
    for (int p = 0; p < 2; p++) begin
      i_fcct_cpu_model.io_wr(2'h0, p ? 8'h67 : 8'h47);
      i_fcct_cpu_model.io_wr(2'h0, 8'h02);
      wait_zero0(600, n);
      wait_zero0(600, n);
      `CHK(n, 2 * (p ? PRESC_DIV_HI : PRESC_DIV_LO))
    end
    i_fcct_cpu_model.io_rd(2'h0, d, ok);
    `CHK({ok, d inside {8'h01, 8'h02}}, 2'b11)
    // external start: nothing may happen before the trigger edge
    i_fcct_cpu_model.io_wr(2'h0, 8'h4f);
    i_fcct_cpu_model.io_wr(2'h0, 8'h01);
    watch(100, hit);
    `CHK(hit[0], 1'b0)
    trig_pulse(4'h1, hit);
    wait_zero0(40, n);
    wait_zero0(40, n);
    `CHK(n, PRESC_DIV_LO)
    i_fcct_cpu_model.io_wr(2'h0, 8'h43);
    watch(300, hit);
    `CHK(hit[0], 1'b0)
    // counter mode on channel 1, interrupt off; constant with bit 0 set
    i_fcct_cpu_model.io_wr(2'h1, 8'h05);
    i_fcct_cpu_model.io_wr(2'h1, 8'h03);
    trig_pulse(4'h2, hit);
    i_fcct_cpu_model.io_rd(2'h1, d, ok);
    `CHK({ok, d, hit}, {1'b1, 8'h02, 3'h0})
    trig_pulse(4'h2, hit);
    trig_pulse(4'h2, hit);
    `CHK({hit, int_n}, 4'b0101)
    i_fcct_cpu_model.io_wr(2'h1, 8'h10);
    i_fcct_cpu_model.io_rd(2'h1, d, ok);
    `CHK({ok, d}, 9'h103)
    // channels 2 and 3 reach zero together with interrupts on
    i_fcct_cpu_model.io_wr(2'h2, 8'h85);
    i_fcct_cpu_model.io_wr(2'h2, 8'h01);
    i_fcct_cpu_model.io_wr(2'h3, 8'h85);
    i_fcct_cpu_model.io_wr(2'h3, 8'h01);
    trig_pulse(4'hc, hit);
    `CHK({hit, int_n, chain_out}, 5'b10000)
    chain_in = 1'b0;
    @(posedge clk);
    #1;
    `CHK({int_n, chain_out}, 2'b10)
    chain_in = 1'b1;
    @(posedge clk);
    #1;
    for (int c = 2; c < 4; c++) begin
      `CHK(int_n, 1'b0)
      i_fcct_cpu_model.int_ack(d, ok);
      `CHK({ok, d}, {1'b1, 5'h15, c[1:0], 1'b0})
      `CHK(chain_out, 1'b0)
      i_fcct_cpu_model.fetch(RETURN_FROM_IRQ_OPCODE_FIRST_BYTE);
      i_fcct_cpu_model.fetch(RETURN_FROM_IRQ_OPCODE_LAST_BYTE);
    end
    `CHK({int_n, chain_out}, 2'b11)
    finish_test();
  end
endmodule : fcct_counter_timer_tb
